// ---- ssu_top.sv ----
// Purpose: Unsigned SIMD subtract, halving subtract and byte SAD datapath.
// Assumes: Decoder resolves condition codes and drives same-clock operands.
// Notes: One cycle from request to registered result and flag write.
//
// Overview of operation
// - Halving halfword subtract: two lanes, halved
// - Halving byte subtract: four lanes, halved
// - Halfword lane difference shifted right one bit
// - Byte lane difference shifted right one bit
// - Omitted destination means first operand register, except in accumulate form
// - Halving and SAD ops leave flags unchanged
// - SAD sums four absolute byte differences
// - Accumulate form adds accumulator source value
// - Plain halfword subtract keeps low sixteen bits
// - Halfword compare flags set in pairs per lane
// - Plain byte subtract keeps low eight bits
// - Byte compare flag n from lane n
// - Failed condition: no result, no flag change
`timescale 1ns/1ps
`include "ssu_defs.svh"

module ssu_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire ssu_pkg::ssu_op_t op_code,
  input wire logic cond_pass,
  input wire logic dest_omitted,
  input wire logic [`SSU_REG_IDX_W-1:0] dest_sel,
  input wire logic [`SSU_REG_IDX_W-1:0] first_sel,
  input wire logic [`SSU_DATA_W-1:0] first_operand,
  input wire logic [`SSU_DATA_W-1:0] second_operand,
  input wire logic [`SSU_DATA_W-1:0] accumulator_source,
  output logic res_valid,
  output logic [`SSU_DATA_W-1:0] res_data,
  output logic [`SSU_REG_IDX_W-1:0] res_dest,
  output logic flags_wr,
  output logic [`SSU_FLAG_W-1:0] lane_compare_flags
);

  ssu_pkg::ssu_state_t st_ff;
  ssu_pkg::ssu_state_t nxt_st;
  ssu_calc_if cif ();

  assign cif.op = op_code;
  assign cif.first_operand = first_operand;
  assign cif.second_operand = second_operand;
  assign cif.accumulator_source = accumulator_source;

  ssu_lane_calc u_calc (
    .cif(cif.calc)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.res_valid = 1'b0;
    nxt_st.flags_wr = 1'b0;
    // Whole instruction is a no-op when its condition fails
    if (op_valid && cond_pass) begin
      case (op_code)
        ssu_pkg::SSU_OP_PLAIN_HALFWORD_SUBTRACT,
        ssu_pkg::SSU_OP_PLAIN_BYTE_SUBTRACT: begin
          nxt_st.res_valid = 1'b1;
          nxt_st.flags_wr = 1'b1;
          nxt_st.lane_compare_flags = cif.lane_compare_flags;
        end
        ssu_pkg::SSU_OP_HALVING_HALFWORD_SUBTRACT,
        ssu_pkg::SSU_OP_HALVING_BYTE_SUBTRACT,
        ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM,
        ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM_ACCUMULATE: begin
          nxt_st.res_valid = 1'b1;
        end
        default: begin
          // Unknown code: nothing written
          nxt_st.res_valid = 1'b0;
        end
      endcase
      // Unknown codes leave the last result and destination in place
      if (nxt_st.res_valid) begin
        nxt_st.res_data = cif.result;
        // Accumulate form always carries an explicit destination
        if (dest_omitted && op_code != ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM_ACCUMULATE) begin
          nxt_st.res_dest = first_sel;
        end else begin
          nxt_st.res_dest = dest_sel;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '{res_valid: 1'b0, res_data: `SSU_DATA_RST, res_dest: `SSU_IDX_RST,
                 flags_wr: 1'b0, lane_compare_flags: `SSU_FLAGS_RST};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign res_valid = st_ff.res_valid;
  assign res_data = st_ff.res_data;
  assign res_dest = st_ff.res_dest;
  assign flags_wr = st_ff.flags_wr;
  assign lane_compare_flags = st_ff.lane_compare_flags;

  // Checks; most fire on a request taken while enabled, the rest on refused, idle, frozen or reset cycles
  logic take;
  assign take = clk_en && op_valid && cond_pass;

  // Reference values built from comparisons, not from the calculator's borrow bits
  logic [`SSU_BYTE_LANES-1:0] chk_byte_ge;
  logic [`SSU_HALF_LANES-1:0] chk_half_ge;
  logic [`SSU_DATA_W-1:0] chk_byte_abs [`SSU_BYTE_LANES];
  logic [`SSU_DATA_W-1:0] chk_abs_sum;
  logic known_op;

  genvar ci;
  generate
    for (ci = 0; ci < `SSU_BYTE_LANES; ci++) begin : g_chk_byte
      assign chk_byte_ge[ci] = first_operand[ci*8 +: 8] >= second_operand[ci*8 +: 8];
      assign chk_byte_abs[ci] = chk_byte_ge[ci]
        ? {24'h00_0000, 8'(first_operand[ci*8 +: 8] - second_operand[ci*8 +: 8])}
        : {24'h00_0000, 8'(second_operand[ci*8 +: 8] - first_operand[ci*8 +: 8])};
    end
    for (ci = 0; ci < `SSU_HALF_LANES; ci++) begin : g_chk_half
      assign chk_half_ge[ci] = first_operand[ci*16 +: 16] >= second_operand[ci*16 +: 16];
    end
  endgenerate

  assign chk_abs_sum = chk_byte_abs[0] + chk_byte_abs[1] + chk_byte_abs[2] + chk_byte_abs[3];
  assign known_op = op_code <= ssu_pkg::SSU_OP_PLAIN_BYTE_SUBTRACT;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_cond_fail_quiet: assert property (
    clk_en && op_valid && !cond_pass |=> !res_valid && !flags_wr && $stable(lane_compare_flags))
    else $error("Failed condition produced a write");

  a_halve_half_lanes: assert property (
    take && op_code == ssu_pkg::SSU_OP_HALVING_HALFWORD_SUBTRACT
    |=> res_data[31:16] == 16'(($past({1'b0, first_operand[31:16]}) - $past({1'b0, second_operand[31:16]})) >> 1)
        && res_data[15:0] == 16'(($past({1'b0, first_operand[15:0]}) - $past({1'b0, second_operand[15:0]})) >> 1))
    else $error("Halving halfword result wrong");

  a_halve_byte_lane: assert property (
    take && op_code == ssu_pkg::SSU_OP_HALVING_BYTE_SUBTRACT
    |=> res_data[31:24] == 8'(($past({1'b0, first_operand[31:24]}) - $past({1'b0, second_operand[31:24]})) >> 1)
        && res_data[7:0] == 8'(($past({1'b0, first_operand[7:0]}) - $past({1'b0, second_operand[7:0]})) >> 1))
    else $error("Halving byte result wrong");

  a_dest_default: assert property (
    take && dest_omitted && op_code != ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM_ACCUMULATE
    |=> res_dest == $past(first_sel))
    else $error("Omitted destination not first operand register");

  a_flags_held: assert property (
    take && (op_code == ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM || op_code == ssu_pkg::SSU_OP_HALVING_BYTE_SUBTRACT)
    |=> !flags_wr && $stable(lane_compare_flags))
    else $error("Flags changed by flag-neutral operation");

  a_sad_equal_acc: assert property (
    take && op_code == ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM_ACCUMULATE && first_operand == second_operand
    |=> res_valid && res_data == $past(accumulator_source))
    else $error("Accumulate of equal operands not the accumulator");

  a_sad_zero_sub: assert property (
    take && op_code == ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM && second_operand == 32'h0000_0000
    |=> res_data == 32'($past(first_operand[7:0])) + 32'($past(first_operand[15:8]))
        + 32'($past(first_operand[23:16])) + 32'($past(first_operand[31:24])))
    else $error("Byte abs diff sum wrong");

  a_plain_half_data: assert property (
    take && op_code == ssu_pkg::SSU_OP_PLAIN_HALFWORD_SUBTRACT
    |=> res_data[15:0] == 16'($past(first_operand[15:0]) - $past(second_operand[15:0])))
    else $error("Plain halfword low lane wrong");

  a_half_flag_pair: assert property (
    take && op_code == ssu_pkg::SSU_OP_PLAIN_HALFWORD_SUBTRACT
    |=> flags_wr && lane_compare_flags[3:2] == {2{$past(first_operand[31:16] >= second_operand[31:16])}})
    else $error("Halfword compare flags wrong");

  a_byte_flag_lane: assert property (
    take && op_code == ssu_pkg::SSU_OP_PLAIN_BYTE_SUBTRACT
    |=> flags_wr && lane_compare_flags[0] == $past(first_operand[7:0] >= second_operand[7:0])
        && lane_compare_flags[3] == $past(first_operand[31:24] >= second_operand[31:24]))
    else $error("Byte compare flags wrong");

  a_sad_full_sum: assert property (
    take && op_code == ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM |=> res_valid && res_data == $past(chk_abs_sum))
    else $error("Byte abs diff sum differs from reference");

  a_sad_bound: assert property (
    take && op_code == ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM
    |=> res_data <= 32'h0000_03FC)
    else $error("Byte abs diff sum above four full bytes");

  a_acc_full_sum: assert property (
    take && op_code == ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM_ACCUMULATE
    |=> res_data == 32'($past(chk_abs_sum) + $past(accumulator_source)))
    else $error("Accumulated sum differs from reference");

  a_halve_byte_mid: assert property (
    take && op_code == ssu_pkg::SSU_OP_HALVING_BYTE_SUBTRACT
    |=> res_data[23:16] == 8'(($past({1'b0, first_operand[23:16]}) - $past({1'b0, second_operand[23:16]})) >> 1)
        && res_data[15:8] == 8'(($past({1'b0, first_operand[15:8]}) - $past({1'b0, second_operand[15:8]})) >> 1))
    else $error("Halving byte middle lanes wrong");

  a_halve_half_borrow: assert property (
    take && op_code == ssu_pkg::SSU_OP_HALVING_HALFWORD_SUBTRACT && !chk_half_ge[1]
    |=> res_data[31])
    else $error("Halving halfword borrow not kept as top bit");

  a_halve_low_borrow: assert property (
    take && op_code == ssu_pkg::SSU_OP_HALVING_HALFWORD_SUBTRACT && !chk_half_ge[0]
    |=> res_data[15])
    else $error("Halving halfword low lane lost its borrow");

  a_halve_byte_borrow: assert property (
    take && op_code == ssu_pkg::SSU_OP_HALVING_BYTE_SUBTRACT && !chk_byte_ge[0]
    |=> res_data[7])
    else $error("Halving byte borrow not kept as top bit");

  a_plain_half_high: assert property (
    take && op_code == ssu_pkg::SSU_OP_PLAIN_HALFWORD_SUBTRACT
    |=> res_data[31:16] == 16'($past(first_operand[31:16]) - $past(second_operand[31:16])))
    else $error("Plain halfword high lane wrong");

  a_plain_byte_data: assert property (
    take && op_code == ssu_pkg::SSU_OP_PLAIN_BYTE_SUBTRACT
    |=> res_data[31:24] == 8'($past(first_operand[31:24]) - $past(second_operand[31:24]))
        && res_data[23:16] == 8'($past(first_operand[23:16]) - $past(second_operand[23:16]))
        && res_data[15:8] == 8'($past(first_operand[15:8]) - $past(second_operand[15:8]))
        && res_data[7:0] == 8'($past(first_operand[7:0]) - $past(second_operand[7:0])))
    else $error("Plain byte lanes wrong");

  a_half_flag_low: assert property (
    take && op_code == ssu_pkg::SSU_OP_PLAIN_HALFWORD_SUBTRACT
    |=> flags_wr && lane_compare_flags[1:0] == {2{$past(chk_half_ge[0])}})
    else $error("Halfword low compare flags wrong");

  a_byte_flag_mid: assert property (
    take && op_code == ssu_pkg::SSU_OP_PLAIN_BYTE_SUBTRACT
    |=> lane_compare_flags[2:1] == $past(chk_byte_ge[2:1]))
    else $error("Byte compare flags of middle lanes wrong");

  a_dest_named: assert property (
    take && known_op && !dest_omitted |=> res_dest == $past(dest_sel))
    else $error("Named destination not used");

  a_acc_dest_explicit: assert property (
    take && op_code == ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM_ACCUMULATE |=> res_dest == $past(dest_sel))
    else $error("Accumulate form did not use its own destination");

  a_flags_kept_rest: assert property (
    take && (op_code == ssu_pkg::SSU_OP_HALVING_HALFWORD_SUBTRACT
             || op_code == ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM_ACCUMULATE)
    |=> !flags_wr && $stable(lane_compare_flags))
    else $error("Flags changed by flag-neutral operation");

  // A reset edge clears the flags without a write pulse
  a_flags_steady: assert property (
    !flags_wr && !$past(rst) |-> $stable(lane_compare_flags))
    else $error("Compare flags moved without a flag write");

  a_cond_fail_hold: assert property (
    clk_en && op_valid && !cond_pass |=> $stable(res_data) && $stable(res_dest))
    else $error("Failed condition changed result or destination");

  a_unknown_quiet: assert property (
    take && !known_op |=> !res_valid && !flags_wr && $stable(res_data) && $stable(res_dest))
    else $error("Unknown operation produced a write");

  a_take_writes: assert property (
    take && known_op |=> res_valid)
    else $error("Passed request gave no write");

  a_pulse_one_cycle: assert property (
    clk_en && !(op_valid && cond_pass) |=> !res_valid && !flags_wr)
    else $error("Write pulse without a passed request");

  a_flags_need_result: assert property (
    flags_wr |-> res_valid)
    else $error("Flag write without a result");

  a_idle_hold: assert property (
    clk_en && !op_valid |=> $stable(res_data) && $stable(res_dest) && $stable(lane_compare_flags))
    else $error("Outputs moved with no request");

  // Reset overrides the enable, so a reset in the window disables this
  a_freeze_hold: assert property (
    !clk_en |=> $stable(res_valid) && $stable(res_data) && $stable(res_dest)
        && $stable(flags_wr) && $stable(lane_compare_flags))
    else $error("State moved while clock enable was low");

  a_reset_clear: assert property (
    disable iff (1'b0) rst |=> !res_valid && !flags_wr && res_data == `SSU_DATA_RST && res_dest == `SSU_IDX_RST
        && lane_compare_flags == `SSU_FLAGS_RST)
    else $error("Reset left outputs set");

endmodule : ssu_top

// ---- ssu_defs.svh ----
// Purpose: Shared constants of the unsigned SIMD subtract and SAD unit.
// Assumes: Included by bare name, definitions only.
// Notes: Widths are fixed; no timing counts exist in this block.
`ifndef SSU_DEFS_SVH
`define SSU_DEFS_SVH

`define SSU_DATA_W 32
`define SSU_REG_IDX_W 4
`define SSU_FLAG_W 4
`define SSU_BYTE_W 8
`define SSU_HALF_W 16
`define SSU_BYTE_LANES 4
`define SSU_HALF_LANES 2
`define SSU_OP_W 3

`define SSU_DATA_RST 32'h0000_0000
`define SSU_IDX_RST 4'h0
`define SSU_FLAGS_RST 4'h0

`endif

// ---- ssu_pkg.sv ----
// Purpose: Types of the unsigned SIMD subtract and SAD unit.
// Assumes: ssu_defs.svh supplies the widths.
// Notes: Operation codes are a local encoding of the decoder hand-off.
`include "ssu_defs.svh"

package ssu_pkg;

  typedef enum logic [`SSU_OP_W-1:0] {
    SSU_OP_HALVING_HALFWORD_SUBTRACT = 3'h0,
    SSU_OP_HALVING_BYTE_SUBTRACT = 3'h1,
    SSU_OP_BYTE_ABS_DIFF_SUM = 3'h2,
    SSU_OP_BYTE_ABS_DIFF_SUM_ACCUMULATE = 3'h3,
    SSU_OP_PLAIN_HALFWORD_SUBTRACT = 3'h4,
    SSU_OP_PLAIN_BYTE_SUBTRACT = 3'h5
  } ssu_op_t;

  typedef struct packed {
    logic res_valid;
    logic [`SSU_DATA_W-1:0] res_data;
    logic [`SSU_REG_IDX_W-1:0] res_dest;
    logic flags_wr;
    logic [`SSU_FLAG_W-1:0] lane_compare_flags;
  } ssu_state_t;

endpackage : ssu_pkg

// ---- ssu_calc_if.sv ----
// Purpose: Carries operands to the lane calculator and its answer back.
// Assumes: Purely combinational path inside one clock domain.
// Notes: None.
`timescale 1ns/1ps
`include "ssu_defs.svh"

interface ssu_calc_if;
  ssu_pkg::ssu_op_t op;
  logic [`SSU_DATA_W-1:0] first_operand;
  logic [`SSU_DATA_W-1:0] second_operand;
  logic [`SSU_DATA_W-1:0] accumulator_source;
  logic [`SSU_DATA_W-1:0] result;
  logic [`SSU_FLAG_W-1:0] lane_compare_flags;

  modport calc (
    input op,
    input first_operand,
    input second_operand,
    input accumulator_source,
    output result,
    output lane_compare_flags
  );

  modport user (
    output op,
    output first_operand,
    output second_operand,
    output accumulator_source,
    input result,
    input lane_compare_flags
  );
endinterface : ssu_calc_if

// ---- ssu_lane_calc.sv ----
// Purpose: Combinational lane arithmetic for all six operations.
// Assumes: Operands are stable for the cycle they are sampled in.
// Notes: No state; the caller registers the answer.
`timescale 1ns/1ps
`include "ssu_defs.svh"

module ssu_lane_calc (
  ssu_calc_if.calc cif
);

  logic [`SSU_BYTE_W:0] byte_diff [`SSU_BYTE_LANES];
  logic [`SSU_BYTE_W-1:0] byte_abs [`SSU_BYTE_LANES];
  logic [`SSU_HALF_W:0] half_diff [`SSU_HALF_LANES];
  logic [`SSU_DATA_W-1:0] sad_sum;

  genvar gi;
  generate
    for (gi = 0; gi < `SSU_BYTE_LANES; gi++) begin : g_byte
      // Extra bit keeps the borrow for halving and the compare flag
      assign byte_diff[gi] = {1'b0, cif.first_operand[gi*8 +: 8]} - {1'b0, cif.second_operand[gi*8 +: 8]};
      assign byte_abs[gi] = byte_diff[gi][`SSU_BYTE_W] ?
        (cif.second_operand[gi*8 +: 8] - cif.first_operand[gi*8 +: 8]) : byte_diff[gi][`SSU_BYTE_W-1:0];
    end
    for (gi = 0; gi < `SSU_HALF_LANES; gi++) begin : g_half
      assign half_diff[gi] = {1'b0, cif.first_operand[gi*16 +: 16]} - {1'b0, cif.second_operand[gi*16 +: 16]};
    end
  endgenerate

  // Full width sum; accumulate wraps modulo 2^32
  assign sad_sum = 32'({24'h00_0000, byte_abs[0]}) + 32'({24'h00_0000, byte_abs[1]})
    + 32'({24'h00_0000, byte_abs[2]}) + 32'({24'h00_0000, byte_abs[3]});

  always_comb begin
    cif.result = `SSU_DATA_RST;
    cif.lane_compare_flags = `SSU_FLAGS_RST;
    case (cif.op)
      ssu_pkg::SSU_OP_HALVING_HALFWORD_SUBTRACT: begin
        cif.result = {half_diff[1][16:1], half_diff[0][16:1]};
      end
      ssu_pkg::SSU_OP_HALVING_BYTE_SUBTRACT: begin
        cif.result = {byte_diff[3][8:1], byte_diff[2][8:1], byte_diff[1][8:1], byte_diff[0][8:1]};
      end
      ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM: begin
        cif.result = sad_sum;
      end
      ssu_pkg::SSU_OP_BYTE_ABS_DIFF_SUM_ACCUMULATE: begin
        cif.result = sad_sum + cif.accumulator_source;
      end
      ssu_pkg::SSU_OP_PLAIN_HALFWORD_SUBTRACT: begin
        cif.result = {half_diff[1][15:0], half_diff[0][15:0]};
        cif.lane_compare_flags = {{2{~half_diff[1][16]}}, {2{~half_diff[0][16]}}};
      end
      ssu_pkg::SSU_OP_PLAIN_BYTE_SUBTRACT: begin
        cif.result = {byte_diff[3][7:0], byte_diff[2][7:0], byte_diff[1][7:0], byte_diff[0][7:0]};
        cif.lane_compare_flags = {~byte_diff[3][8], ~byte_diff[2][8], ~byte_diff[1][8], ~byte_diff[0][8]};
      end
      default: begin
        cif.result = `SSU_DATA_RST;
      end
    endcase
  end

endmodule : ssu_lane_calc

// ---- ssu_regfile_model.sv ----
// Purpose: Register file on the far side of the unit, taking its write-backs.
// Assumes: One write port driven by res_valid, res_dest and res_data.
// Notes: Operands are supplied by the bench, which plays the decoder.
`timescale 1ns/1ps

module ssu_regfile_model (
  input wire logic ref_clk,
  input wire logic res_valid,
  input wire logic [31:0] res_data,
  input wire logic [3:0] res_dest
);
  logic [31:0] regs [16];

  // Bench never names stack pointer or program counter indices 13..15
  always_ff @(posedge ref_clk) begin
    if (res_valid === 1'b1) begin
      regs[res_dest] <= res_data;
    end
  end
endmodule : ssu_regfile_model

// ---- test_unsigned_simd_sub_sad_unit.sv ----
// Purpose: Self-checking bench of the subtract, halving subtract and SAD unit.
// Assumes: Inputs change at the falling edge; results checked at the next falling edge.
// Notes: Expected values come from lane arithmetic written here.
`timescale 1ns/1ps

module test_unsigned_simd_sub_sad_unit;
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, op_valid = 1'b0, cond_pass = 1'b0, dest_omitted = 1'b0;
  ssu_pkg::ssu_op_t op_code = ssu_pkg::SSU_OP_HALVING_HALFWORD_SUBTRACT;
  logic [3:0] dest_sel = 4'h0, first_sel = 4'h0, res_dest;
  logic [31:0] first_operand = 32'h0000_0000, second_operand = 32'h0000_0000, accumulator_source = 32'h0000_0000;
  logic res_valid, flags_wr;
  logic [31:0] res_data, held_data;
  logic [3:0] lane_compare_flags, held_flags, held_dest;
  int n_errors = 0, checks = 0, cyc = 0;

  ssu_top dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code),
    .cond_pass(cond_pass), .dest_omitted(dest_omitted), .dest_sel(dest_sel), .first_sel(first_sel),
    .first_operand(first_operand), .second_operand(second_operand), .accumulator_source(accumulator_source),
    .res_valid(res_valid), .res_data(res_data), .res_dest(res_dest), .flags_wr(flags_wr),
    .lane_compare_flags(lane_compare_flags));
  ssu_regfile_model u_rf (.ref_clk(ref_clk), .res_valid(res_valid), .res_data(res_data), .res_dest(res_dest));

  initial forever #25 ref_clk = ~ref_clk;

  task automatic close_out;
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // Hang guard: the whole run needs well under 200 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      $display("MISMATCH %0t timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk

  function automatic logic [31:0] f_res(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
                                        input logic [31:0] c);
    logic [31:0] r;
    logic [8:0] d;
    logic [16:0] h;
    r = (op == 3'h3) ? c : 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      d = {1'b0, a[8*i+:8]} - {1'b0, b[8*i+:8]};
      if (op == 3'h1) r[8*i+:8] = d[8:1];
      if (op == 3'h5) r[8*i+:8] = d[7:0];
      if (op == 3'h2 || op == 3'h3) r = r + ((a[8*i+:8] > b[8*i+:8]) ? {24'h00_0000, a[8*i+:8] - b[8*i+:8]}
                                                                  : {24'h00_0000, b[8*i+:8] - a[8*i+:8]});
    end
    for (int i = 0; i < 2; i++) begin
      h = {1'b0, a[16*i+:16]} - {1'b0, b[16*i+:16]};
      if (op == 3'h0) r[16*i+:16] = h[16:1];
      if (op == 3'h4) r[16*i+:16] = h[15:0];
    end
    return r;
  endfunction : f_res

  // One request; stays asserted so calls run back to back
  task automatic run(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                     input logic cnd, input logic omit, input logic [3:0] ds, input logic [3:0] fs);
    logic wr;
    wr = cnd && (op <= 3'h5);
    op_valid = 1'b1;
    op_code = ssu_pkg::ssu_op_t'(op);
    first_operand = a;
    second_operand = b;
    accumulator_source = c;
    cond_pass = cnd;
    dest_omitted = omit;
    dest_sel = ds;
    first_sel = fs;
    if (wr) begin
      held_data = f_res(op, a, b, c);
      held_dest = (omit && op != 3'h3) ? fs : ds;
    end
    if (wr && op == 3'h5) for (int i = 0; i < 4; i++) held_flags[i] = a[8*i+:8] >= b[8*i+:8];
    if (wr && op == 3'h4) held_flags = {{2{a[31:16] >= b[31:16]}}, {2{a[15:0] >= b[15:0]}}};
    @(negedge ref_clk);
    chk(res_valid === wr, "result valid");
    chk(flags_wr === (wr && op >= 3'h4), "flag write");
    chk(res_data === held_data, "result data");
    chk(res_dest === held_dest, "result dest");
    chk(lane_compare_flags === held_flags, "compare flags");
  endtask : run

  task automatic idle;
    op_valid = 1'b0;
    @(negedge ref_clk);
    chk(res_valid === 1'b0 && flags_wr === 1'b0, "pulse too long");
  endtask : idle

  task automatic t_halving;
    run(3'h0, 32'h0003_1000, 32'h0005_0001, 32'h0, 1'b1, 1'b0, 4'h2, 4'h1);
    run(3'h1, 32'h0010_FF01, 32'h0101_00FF, 32'h0, 1'b1, 1'b0, 4'h3, 4'h1);
    idle();
  endtask : t_halving

  task automatic t_sad;
    run(3'h2, 32'h1280_FF03, 32'h0000_0000, 32'h0, 1'b1, 1'b0, 4'h4, 4'h6);
    run(3'h3, 32'h5A5A_1234, 32'h5A5A_1234, 32'hDEAD_0001, 1'b1, 1'b0, 4'h3, 4'h6);
    run(3'h2, 32'hFF00_8001, 32'h00FF_0180, 32'h0, 1'b1, 1'b1, 4'h2, 4'h6);
    run(3'h3, 32'hFF00_8001, 32'h00FF_0180, 32'hFFFF_FFF0, 1'b1, 1'b0, 4'h7, 4'h6);
    idle();
    chk(u_rf.regs[7] === held_data, "register file write");
    chk(u_rf.regs[7] === 32'h0000_02EC, "accumulate wrap");
  endtask : t_sad

  task automatic t_plain;
    run(3'h4, 32'h8000_0001, 32'h7FFF_0002, 32'h0, 1'b1, 1'b0, 4'h4, 4'h5);
    run(3'h5, 32'h0180_7F05, 32'h0280_8004, 32'h0, 1'b1, 1'b1, 4'h4, 4'h5);
    run(3'h0, 32'h0000_0000, 32'h1234_5678, 32'h0, 1'b1, 1'b0, 4'h1, 4'h0);
    run(3'h3, 32'h0000_0000, 32'h0000_0001, 32'h1, 1'b1, 1'b0, 4'h1, 4'h0);
    idle();
  endtask : t_plain

  task automatic t_refused;
    run(3'h5, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0, 1'b0, 1'b0, 4'h8, 4'h9);
    run(3'h4, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0, 1'b0, 1'b0, 4'h8, 4'h9);
    run(3'h6, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0, 1'b1, 1'b0, 4'h8, 4'h9);
    idle();
  endtask : t_refused

  // Enable low freezes the write pulse and results; reset still acts while frozen
  task automatic t_freeze;
    run(3'h5, 32'h0180_0302, 32'h0101_0101, 32'h0, 1'b1, 1'b0, 4'h2, 4'h3);
    clk_en = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(res_valid === 1'b1 && res_data === 32'h007F_0201 && lane_compare_flags === 4'hF, "frozen");
    rst = 1'b1;
    @(negedge ref_clk);
    chk(res_valid === 1'b0 && flags_wr === 1'b0 && res_data === 32'h0000_0000 && res_dest === 4'h0
        && lane_compare_flags === 4'h0, "reset while frozen");
    rst = 1'b0;
    clk_en = 1'b1;
    idle();
  endtask : t_freeze

  initial begin
    held_data = 32'h0000_0000;
    held_dest = 4'h0;
    held_flags = 4'h0;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk(res_valid === 1'b0 && res_data === 32'h0000_0000 && lane_compare_flags === 4'h0, "reset state");
    t_halving();
    t_sad();
    t_plain();
    t_refused();
    t_freeze();
    close_out();
  end
endmodule : test_unsigned_simd_sub_sad_unit
